/* File: core/rtc_pkg.sv */
// Shared register map, field positions, reset values and timing for the timekeeping core
package rtc_pkg;
	localparam int REF_CLK_HZ = 100_000_000;

	// Register addresses inside the 0x00..0x1f timekeeping range
	localparam logic [4:0] ADDR_SEC = 5'h00;
	localparam logic [4:0] ADDR_MIN = 5'h01;
	localparam logic [4:0] ADDR_HOUR = 5'h02;
	localparam logic [4:0] ADDR_WEEKDAY_VALUE = 5'h03;
	localparam logic [4:0] ADDR_DATE = 5'h04;
	localparam logic [4:0] ADDR_MONTH = 5'h05;
	localparam logic [4:0] ADDR_YEAR = 5'h06;
	localparam logic [4:0] ADDR_CTRL = 5'h07;
	localparam logic [7:0] ADDR_LAST = 8'h1f;
	localparam logic [4:0] NUM_LIVE = 5'h08;

	// Field positions
	localparam int OSC_START_BIT = 7;
	localparam int HOUR_FMT_BIT = 6;
	localparam int PM_BIT = 5;
	localparam int RUN_BIT = 5;
	localparam int LEAP_BIT = 5;
	localparam int EXT_EN_BIT = 3;

	// Power-on values
	localparam logic [7:0] SEC_RST = 8'h00;
	localparam logic [7:0] MIN_RST = 8'h00;
	localparam logic [7:0] HOUR_RST = 8'h00;
	localparam logic [7:0] WEEKDAY_VALUE_RST = 8'h01;
	localparam logic [7:0] DATE_RST = 8'h01;
	localparam logic [7:0] MONTH_RST = 8'h01;
	localparam logic [7:0] YEAR_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// Writable bits per register; the rest read as zero or as live status
	localparam logic [7:0] SEC_WMASK = 8'hff;
	localparam logic [7:0] MIN_WMASK = 8'h7f;
	localparam logic [7:0] HOUR_WMASK = 8'h7f;
	localparam logic [7:0] WEEKDAY_VALUE_WMASK = 8'h1f;
	localparam logic [7:0] DATE_WMASK = 8'h3f;
	localparam logic [7:0] MONTH_WMASK = 8'h1f;
	localparam logic [7:0] YEAR_WMASK = 8'hff;
	localparam logic [7:0] CTRL_WMASK = 8'hff;

	// Timing
	localparam int OSC_RUN_EDGES = 32;
	localparam int SEC_DIVIDE = 32768;
	localparam int OSC_FAIL_TIMEOUT_US = 1000;
	localparam int OSC_FAIL_CYC = OSC_FAIL_TIMEOUT_US * (REF_CLK_HZ / 1_000_000);

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_ACTIVE = 2'b10
	} rd_state_t;
endpackage : rtc_pkg

/* File: core/osc_monitor.sv */
// Oscillator running detector: edge counter plus missing-edge timeout
`timescale 1ns/1ps
module osc_monitor
	import rtc_pkg::*;
#(
	parameter int RUN_EDGES = OSC_RUN_EDGES,
	parameter int FAIL_CYCLES = OSC_FAIL_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Oscillator edge from the selected, enabled source
	input wire logic osc_edge,
	// Status
	output logic osc_running
);
	if (RUN_EDGES < 1 || RUN_EDGES > 255) $error("RUN_EDGES out of range");
	if (FAIL_CYCLES < 1) $error("FAIL_CYCLES must be positive");

	logic [7:0] edge_cnt_r;
	logic [31:0] idle_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			edge_cnt_r <= 8'h00;
			idle_r <= 32'h0;
			osc_running <= 1'b0;
		end else if (osc_edge) begin
			idle_r <= 32'h0;
			if (edge_cnt_r < 8'(RUN_EDGES))
				edge_cnt_r <= edge_cnt_r + 8'h01;
			if (edge_cnt_r == 8'(RUN_EDGES - 1))
				osc_running <= 1'b1; // [RL3]
		end else if (idle_r == 32'(FAIL_CYCLES)) begin
			// Timeout also restarts the count, so a restart needs a fresh run of edges
			osc_running <= 1'b0; // [RL4]
			edge_cnt_r <= 8'h00;
		end else begin
			idle_r <= idle_r + 32'h1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	run_set_a: assert property ($rose(osc_running) |-> $past(edge_cnt_r) == 8'(RUN_EDGES - 1)) // [RL3]
		else $error("running flag set without the required edge count");
	run_clear_a: assert property (idle_r == 32'(FAIL_CYCLES) && !osc_edge |=> !osc_running) // [RL4]
		else $error("running flag kept after oscillator timeout");
endmodule : osc_monitor

/* File: core/sec_divider.sv */
// Divides the oscillator edge stream down to a one-second tick
`timescale 1ns/1ps
module sec_divider
	import rtc_pkg::*;
#(
	parameter int DIVIDE = SEC_DIVIDE
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Oscillator
	input wire logic osc_edge,
	input wire logic run_en,
	// Tick
	output logic sec_tick
);
	if (DIVIDE < 2 || DIVIDE > 65536) $error("DIVIDE out of range");

	logic [15:0] div_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_r <= 16'h0000;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= 1'b0;
			// A disabled source holds the prescaler so partial seconds survive a pause
			if (osc_edge && run_en) begin // [RL22]
				if (div_r == 16'(DIVIDE - 1)) begin
					div_r <= 16'h0000;
					sec_tick <= 1'b1;
				end else begin
					div_r <= div_r + 16'h0001;
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	tick_enabled_a: assert property (sec_tick |-> $past(run_en) && $past(osc_edge)) // [RL22]
		else $error("second tick without an enabled source edge");
endmodule : sec_divider

/* File: core/rtc_timekeeper.sv */
// Timekeeping core: oscillator control, BCD calendar and buffered register reads
`timescale 1ns/1ps
//Contract
// RL1 - Seconds bit 7 starts the crystal oscillator; host sets it to run.
// RL2 - External clock on the input pin needs the external clock enable set.
// RL3 - Running flag sets after 32 oscillator edges are seen.
// RL4 - Running flag clears when no edge is seen beyond the failure timeout.
// RL5 - All time and date values are kept in BCD.
// RL6 - Two-digit year with leap-year correction from 2001 to 2399; the core treats every year 00 as leap.
// RL7 - Both 12-hour and 24-hour formats, chosen by the format bit.
// RL8 - Weekday counts 1 to 7 and advances at midnight, meaning user-defined.
// RL9 - Reads come from a snapshot refreshed when a read starts in 0x00..0x1f.
// RL10 - Snapshot refreshes again when the read address wraps 0x1f to 0x00.
// RL11 - Host should read all time registers in one read transaction.
// RL12 - Host stops the source and waits for not-running before loading time.
// RL13 - Host writes only valid time and date values.
// RL14 - Midnight rollover in either format carries into date and weekday.
// RL15 - Weekday wraps 7 to 1 with no carry.
// RL16 - Date carries to month after the month's last day, February by leap.
// RL17 - Past December 31 month and date become 01/01 and year increments.
// RL18 - Year wraps 99 to 00 with no carry.
// RL19 - Seconds tens in bits 6-4, ones in bits 3-0, all clear at power-on.
// RL20 - Format bit 1 selects 12-hour, 0 selects 24-hour.
// RL21 - In 12-hour format bit 5 is PM, toggled passing 11 to 12.
// RL22 - One second is 32768 edges of the enabled source.
// RL23 - 12-hour counts 12,1..11; 24-hour counts 00..23.
module rtc_timekeeper
	import rtc_pkg::*;
#(
	parameter int FAIL_CYCLES = OSC_FAIL_CYC,
	parameter int DIVIDE = SEC_DIVIDE
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Oscillator pins
	input wire logic clk_in_pin,
	output logic xtal_out_pin,
	// Register write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Register read port
	input wire logic rd_begin,
	input wire logic [7:0] rd_addr,
	input wire logic rd_next,
	input wire logic rd_end,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	logic [7:0] sec_r, min_r, hour_r, weekday_value_r, date_r, month_r, year_r, ctrl_r;
	logic [7:0] sec_nxt, min_nxt, hour_nxt, weekday_value_nxt, date_nxt, month_nxt, year_nxt;
	logic min_c, hr_c, day_c, mon_c;
	logic pin_d_r, osc_edge, src_en, osc_running, sec_tick, leap;
	logic [63:0] live_flat, snap_r;
	logic [7:0] live_at_addr, live_at_ptr, snap_at_ptr;
	logic [4:0] ptr_r;
	rd_state_t rd_state_r;
	logic addr_ok;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return {v[7:4], v[3:0] + 4'h1};
	endfunction : bcd_inc

	// Year 00 is treated like 2000 and 2400, both leap; 2100..2300 fall outside
	function automatic logic is_leap(input logic [7:0] yr);
		if (yr[4])
			return (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
		return (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
	endfunction : is_leap

	function automatic logic [5:0] last_day(input logic [4:0] mon, input logic lp);
		case (mon)
			5'h02: return lp ? 6'h29 : 6'h28;
			5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
			default: return 6'h31;
		endcase
	endfunction : last_day

	function automatic logic [7:0] pick(input logic [4:0] a, input logic [63:0] flat);
		if (a < NUM_LIVE)
			return flat[a[2:0] * 8 +: 8];
		return 8'h00;
	endfunction : pick

	// Oscillator source; the pin is sampled as a synchronous input
	assign src_en = sec_r[OSC_START_BIT] | ctrl_r[EXT_EN_BIT]; // [RL1] [RL2]
	assign osc_edge = clk_in_pin & ~pin_d_r & src_en;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_d_r <= 1'b0;
			xtal_out_pin <= 1'b0;
		end else begin
			pin_d_r <= clk_in_pin;
			// Inverting drive only in crystal mode; pin left quiet for an external clock
			xtal_out_pin <= sec_r[OSC_START_BIT] & ~ctrl_r[EXT_EN_BIT] & ~clk_in_pin; // [RL1]
		end
	end

	osc_monitor #(
		.RUN_EDGES(OSC_RUN_EDGES),
		.FAIL_CYCLES(FAIL_CYCLES)
	) u_mon (
		.ref_clk(ref_clk),
		.rst(rst),
		.osc_edge(osc_edge),
		.osc_running(osc_running)
	);

	sec_divider #(
		.DIVIDE(DIVIDE)
	) u_div (
		.ref_clk(ref_clk),
		.rst(rst),
		.osc_edge(osc_edge),
		.run_en(src_en),
		.sec_tick(sec_tick)
	);

	assign leap = is_leap(year_r); // [RL6]

	// Calendar carry chain, all in BCD
	always_comb begin
		sec_nxt = sec_r;
		min_nxt = min_r;
		hour_nxt = hour_r;
		weekday_value_nxt = weekday_value_r;
		date_nxt = date_r;
		month_nxt = month_r;
		year_nxt = year_r;
		min_c = 1'b0;
		hr_c = 1'b0;
		day_c = 1'b0;
		mon_c = 1'b0;
		if (sec_tick) begin
			if (sec_r[6:0] == 7'h59) begin // [RL19]
				sec_nxt[6:0] = 7'h00;
				min_c = 1'b1;
			end else begin
				sec_nxt[6:0] = 7'(bcd_inc({1'b0, sec_r[6:0]})); // [RL5]
			end
		end
		if (min_c) begin
			if (min_r[6:0] == 7'h59) begin
				min_nxt[6:0] = 7'h00;
				hr_c = 1'b1;
			end else begin
				min_nxt[6:0] = 7'(bcd_inc({1'b0, min_r[6:0]}));
			end
		end
		if (hr_c) begin
			if (hour_r[HOUR_FMT_BIT]) begin // [RL7] [RL20]
				if (hour_r[4:0] == 5'h11) begin
					hour_nxt[4:0] = 5'h12;
					hour_nxt[PM_BIT] = ~hour_r[PM_BIT]; // [RL21]
					day_c = hour_r[PM_BIT]; // [RL14]
				end else if (hour_r[4:0] == 5'h12) begin
					hour_nxt[4:0] = 5'h01; // [RL23]
				end else begin
					hour_nxt[4:0] = 5'(bcd_inc({3'b000, hour_r[4:0]}));
				end
			end else if (hour_r[5:0] == 6'h23) begin
				hour_nxt[5:0] = 6'h00; // [RL23]
				day_c = 1'b1; // [RL14]
			end else begin
				hour_nxt[5:0] = 6'(bcd_inc({2'b00, hour_r[5:0]}));
			end
		end
		if (day_c) begin
			// Weekday wrap feeds nothing further
			weekday_value_nxt[2:0] = (weekday_value_r[2:0] == 3'h7) ? 3'h1 : weekday_value_r[2:0] + 3'h1; // [RL8] [RL15]
			if (date_r[5:0] == last_day(month_r[4:0], leap)) begin // [RL16]
				date_nxt[5:0] = 6'h01;
				mon_c = 1'b1;
			end else begin
				date_nxt[5:0] = 6'(bcd_inc({2'b00, date_r[5:0]}));
			end
		end
		if (mon_c) begin
			if (month_r[4:0] == 5'h12) begin
				month_nxt[4:0] = 5'h01; // [RL17]
				year_nxt = (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r); // [RL18]
			end else begin
				month_nxt[4:0] = 5'(bcd_inc({3'b000, month_r[4:0]}));
			end
		end
	end

	// Time registers: a host write to a register beats the tick on that register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sec_r <= SEC_RST; // [RL19]
			min_r <= MIN_RST;
			hour_r <= HOUR_RST;
			weekday_value_r <= WEEKDAY_VALUE_RST;
			date_r <= DATE_RST;
			month_r <= MONTH_RST;
			year_r <= YEAR_RST;
		end else begin
			sec_r <= (wr_en && wr_addr == {3'b000, ADDR_SEC}) ? (wr_data & SEC_WMASK) : sec_nxt;
			min_r <= (wr_en && wr_addr == {3'b000, ADDR_MIN}) ? (wr_data & MIN_WMASK) : min_nxt;
			hour_r <= (wr_en && wr_addr == {3'b000, ADDR_HOUR}) ? (wr_data & HOUR_WMASK) : hour_nxt;
			weekday_value_r <= (wr_en && wr_addr == {3'b000, ADDR_WEEKDAY_VALUE}) ?
				(wr_data & WEEKDAY_VALUE_WMASK) : weekday_value_nxt;
			date_r <= (wr_en && wr_addr == {3'b000, ADDR_DATE}) ? (wr_data & DATE_WMASK) : date_nxt;
			month_r <= (wr_en && wr_addr == {3'b000, ADDR_MONTH}) ?
				(wr_data & MONTH_WMASK) : month_nxt;
			year_r <= (wr_en && wr_addr == {3'b000, ADDR_YEAR}) ? (wr_data & YEAR_WMASK) : year_nxt;
		end
	end

	// Control register: only the external clock enable is used by this core
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			ctrl_r <= CTRL_RST;
		else if (wr_en && wr_addr == {3'b000, ADDR_CTRL})
			ctrl_r <= wr_data & CTRL_WMASK; // [RL2]
	end

	// Live view with status bits merged in
	assign live_flat = {ctrl_r, year_r,
		month_r | (8'(leap) << LEAP_BIT),
		date_r,
		weekday_value_r | (8'(osc_running) << RUN_BIT),
		hour_r, min_r, sec_r};
	assign addr_ok = rd_addr <= ADDR_LAST;
	assign live_at_addr = pick(rd_addr[4:0], live_flat);
	assign live_at_ptr = pick(ptr_r, live_flat);
	assign snap_at_ptr = pick(ptr_r, snap_r);

	// Buffered read: the snapshot keeps a multi-byte read coherent across a tick
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_state_r <= RD_IDLE;
			snap_r <= 64'h0;
			ptr_r <= 5'h00;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			case (rd_state_r)
				RD_IDLE: begin
					if (rd_begin && addr_ok) begin
						snap_r <= live_flat; // [RL9]
						rd_data <= live_at_addr;
						rd_valid <= 1'b1;
						ptr_r <= rd_addr[4:0] + 5'h01;
						rd_state_r <= RD_ACTIVE;
					end
				end
				RD_ACTIVE: begin
					if (rd_begin && addr_ok) begin
						snap_r <= live_flat; // [RL9]
						rd_data <= live_at_addr;
						rd_valid <= 1'b1;
						ptr_r <= rd_addr[4:0] + 5'h01;
					end else if (rd_begin || rd_end) begin
						rd_state_r <= RD_IDLE;
					end else if (rd_next) begin
						if (ptr_r == 5'h00) begin
							snap_r <= live_flat; // [RL10]
							rd_data <= live_at_ptr;
						end else begin
							rd_data <= snap_at_ptr;
						end
						rd_valid <= 1'b1;
						ptr_r <= ptr_r + 5'h01;
					end
				end
				default: rd_state_r <= RD_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence rd_start_s;
		rd_begin && addr_ok;
	endsequence
	sequence rd_wrap_s;
		rd_state_r == RD_ACTIVE && !rd_begin && !rd_end && rd_next && ptr_r == 5'h00;
	endsequence
	sequence midnight_s;
		hr_c && day_c && !wr_en;
	endsequence
	sequence snap_step_s;
		rd_state_r == RD_ACTIVE && !rd_begin && !rd_end && rd_next && ptr_r != 5'h00;
	endsequence

	read_refresh_a: assert property (rd_start_s // [RL9]
		|=> rd_valid && rd_data == $past(live_at_addr))
		else $error("read start did not return the live value");
	wrap_refresh_a: assert property (rd_wrap_s // [RL10]
		|=> rd_valid && snap_r == $past(live_flat))
		else $error("address wrap did not refresh the snapshot");
	snap_read_a: assert property (snap_step_s // [RL9]
		|=> rd_valid && rd_data == $past(snap_at_ptr))
		else $error("buffered read did not return the snapshot byte");
	idle_quiet_a: assert property (rd_state_r == RD_IDLE && !rd_begin |=> !rd_valid) // [RL9]
		else $error("read answer given without a request");
	sec_wrap_a: assert property (sec_tick && sec_r[6:0] == 7'h59 && !wr_en // [RL19]
		|=> sec_r[6:0] == 7'h00)
		else $error("seconds did not wrap at 59");
	bcd_digit_a: assert property (sec_tick && sec_r[3:0] == 4'h9 && sec_r[6:4] != 3'h5 // [RL5]
		&& !wr_en |=> sec_r[3:0] == 4'h0 && sec_r[6:4] == $past(sec_r[6:4]) + 3'h1)
		else $error("seconds ones digit did not carry in BCD");
	midnight24_a: assert property ((midnight_s and !hour_r[HOUR_FMT_BIT]) // [RL14]
		|=> hour_r[5:0] == 6'h00 && weekday_value_r != $past(weekday_value_r))
		else $error("24-hour midnight did not roll over");
	midnight12_a: assert property ((midnight_s and hour_r[HOUR_FMT_BIT]) // [RL14]
		|=> hour_r[4:0] == 5'h12 && !hour_r[PM_BIT] && weekday_value_r != $past(weekday_value_r))
		else $error("12-hour midnight did not carry into the weekday");
	pm_toggle_a: assert property (hr_c && hour_r[HOUR_FMT_BIT] && hour_r[4:0] == 5'h11 // [RL21]
		&& !wr_en |=> hour_r[4:0] == 5'h12 && hour_r[PM_BIT] != $past(hour_r[PM_BIT]))
		else $error("12-hour indicator did not toggle at 12");
	hour12_wrap_a: assert property (hr_c && hour_r[HOUR_FMT_BIT] && hour_r[4:0] == 5'h12 // [RL23]
		&& !wr_en |=> hour_r[4:0] == 5'h01)
		else $error("12-hour count did not wrap 12 to 1");
	hour24_a: assert property (hr_c && !hour_r[HOUR_FMT_BIT] && hour_r[5:0] == 6'h09 // [RL7]
		&& !wr_en |=> hour_r[5:0] == 6'h10)
		else $error("24-hour count did not carry 09 to 10");
	weekday_value_wrap_a: assert property ((midnight_s and weekday_value_r[2:0] == 3'h7) // [RL15]
		|=> weekday_value_r[2:0] == 3'h1)
		else $error("weekday did not wrap to 1");
	feb_end_a: assert property (day_c && !wr_en && month_r[4:0] == 5'h02 // [RL16]
		&& date_r[5:0] == 6'h28 && !leap |=> date_r[5:0] == 6'h01 && month_r[4:0] == 5'h03)
		else $error("February end mishandled");
	feb29_a: assert property (day_c && !wr_en && month_r[4:0] == 5'h02 // [RL6]
		&& date_r[5:0] == 6'h28 && leap |=> date_r[5:0] == 6'h29 && month_r[4:0] == 5'h02)
		else $error("leap-year February ended at 28");
	month30_a: assert property (day_c && !wr_en && month_r[4:0] == 5'h04 // [RL16]
		&& date_r[5:0] == 6'h30 |=> date_r[5:0] == 6'h01 && month_r[4:0] == 5'h05)
		else $error("30-day month did not end at 30");
	year_end_a: assert property (mon_c && !wr_en && month_r[4:0] == 5'h12 // [RL17]
		|=> month_r[4:0] == 5'h01 && date_r[5:0] == 6'h01 && year_r != $past(year_r))
		else $error("year end did not roll to 01/01");
	year_wrap_a: assert property (mon_c && !wr_en && month_r[4:0] == 5'h12 && year_r == 8'h99 // [RL18]
		|=> year_r == 8'h00)
		else $error("year did not wrap 99 to 00");
	// A tick already in flight when the source drops may still land, so look one cycle back
	stopped_hold_a: assert property (!src_en && !$past(src_en) && !wr_en // [RL22]
		|=> sec_r == $past(sec_r))
		else $error("seconds advanced with the source disabled");
	xtal_quiet_a: assert property (!sec_r[OSC_START_BIT] |=> !xtal_out_pin) // [RL1]
		else $error("crystal drive active with the oscillator stopped");
endmodule : rtc_timekeeper

/* File: bench/host_model.sv */
// Host model: register writes and buffered byte-stream reads on the register port
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic ref_clk,
	// Write port
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	// Read port
	output logic rd_begin,
	output logic [7:0] rd_addr,
	output logic rd_next,
	output logic rd_end,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	initial begin
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_begin = 1'b0;
		rd_addr = 8'h00;
		rd_next = 1'b0;
		rd_end = 1'b0;
	end

	// Released lines show the inverse so a stale byte is never mistaken for a held one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge ref_clk);
		wr_en = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
	endtask : wr

	// Answer is a one-cycle pulse, so it is looked for at every falling edge
	task automatic take(output logic [7:0] d, output bit ok);
		int k;
		k = 0;
		while (rd_valid !== 1'b1 && k < 4) begin
			@(negedge ref_clk);
			k++;
		end
		ok = (rd_valid === 1'b1);
		d = rd_data;
	endtask : take

	task automatic rd_first(input logic [7:0] a, output logic [7:0] d, output bit ok);
		@(negedge ref_clk);
		rd_begin = 1'b1;
		rd_addr = a;
		@(negedge ref_clk);
		rd_begin = 1'b0;
		rd_addr = ~a;
		take(d, ok);
	endtask : rd_first

	task automatic rd_more(output logic [7:0] d, output bit ok);
		@(negedge ref_clk);
		rd_next = 1'b1;
		@(negedge ref_clk);
		rd_next = 1'b0;
		take(d, ok);
	endtask : rd_more

	task automatic rd_stop();
		@(negedge ref_clk);
		rd_end = 1'b1;
		@(negedge ref_clk);
		rd_end = 1'b0;
	endtask : rd_stop
endmodule : host_model

/* File: bench/rtc_timekeeper_tb.sv */
// Self-checking bench for the timekeeping core: reset map, oscillator status, calendar carries
`timescale 1ns/1ps
module rtc_timekeeper_tb;
	import rtc_pkg::*;
	localparam int FAIL = 50;
	localparam int DIV = 4;
	localparam logic [7:0] RST_MAP [8] = '{SEC_RST, MIN_RST, HOUR_RST, WEEKDAY_VALUE_RST,
		DATE_RST, MONTH_RST | 8'h20, YEAR_RST, CTRL_RST};
	typedef logic [7:0] regs_t [7];
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_in_pin = 1'b0;
	logic xtal_out_pin, wr_en, rd_begin, rd_next, rd_end, rd_valid;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
	logic [7:0] q [$];
	int n_errors = 0;
	int num_checks = 0;

	always #5 ref_clk = ~ref_clk;

	// Short counts keep the run brief; expectations use the same values
	rtc_timekeeper #(.FAIL_CYCLES(FAIL), .DIVIDE(DIV)) dut_u (.ref_clk(ref_clk), .rst(rst),
		.clk_in_pin(clk_in_pin), .xtal_out_pin(xtal_out_pin), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_begin(rd_begin), .rd_addr(rd_addr),
		.rd_next(rd_next), .rd_end(rd_end), .rd_data(rd_data), .rd_valid(rd_valid));
	host_model host_u (.ref_clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_begin(rd_begin), .rd_addr(rd_addr), .rd_next(rd_next),
		.rd_end(rd_end), .rd_data(rd_data), .rd_valid(rd_valid));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("Checks made %0d, mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic edges(input int n);
		repeat (n) begin
			@(negedge ref_clk);
			clk_in_pin = 1'b1;
			repeat (2) @(negedge ref_clk);
			clk_in_pin = 1'b0;
			@(negedge ref_clk);
		end
	endtask : edges

	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] d;
		bit ok;
		q.delete();
		host_u.rd_first(a, d, ok);
		check({7'h00, ok}, 8'h01);
		q.push_back(d);
		repeat (n - 1) begin
			host_u.rd_more(d, ok);
			check({7'h00, ok}, 8'h01);
			q.push_back(d);
		end
		host_u.rd_stop();
	endtask : rd

	function automatic int bcd2i(input logic [7:0] b);
		return int'(b[7:4]) * 10 + int'(b[3:0]);
	endfunction : bcd2i

	function automatic logic [7:0] i2bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction : i2bcd

	// Two-digit year cannot tell centuries apart, so every fourth year is leap
	function automatic int mdays(input int mo, input int y);
		case (mo)
			2: return (y % 4 == 0) ? 29 : 28;
			4, 6, 9, 11: return 30;
			default: return 31;
		endcase
	endfunction : mdays

	function automatic regs_t next_time(input regs_t t);
		regs_t r;
		int s, m, h, d, mo, y, wk;
		bit pm, f12, day;
		s = bcd2i(t[0] & 8'h7f) + 1;
		m = bcd2i(t[1]);
		f12 = t[2][HOUR_FMT_BIT];
		pm = t[2][PM_BIT] & f12;
		h = f12 ? bcd2i(t[2] & 8'h1f) : bcd2i(t[2] & 8'h3f);
		wk = t[3][2:0];
		d = bcd2i(t[4]);
		mo = bcd2i(t[5] & 8'h1f);
		y = bcd2i(t[6]);
		day = 1'b0;
		if (s == 60) begin
			s = 0;
			m++;
		end
		if (m == 60) begin
			m = 0;
			h++;
			if (f12 && h == 12) begin
				pm = ~pm;
				day = ~pm;
			end else if (f12 && h == 13) h = 1;
			else if (!f12 && h == 24) begin
				h = 0;
				day = 1'b1;
			end
		end
		if (day) begin
			wk = (wk == 7) ? 1 : wk + 1;
			d++;
			if (d > mdays(mo, y)) begin
				d = 1;
				mo++;
			end
			if (mo == 13) begin
				mo = 1;
				y = (y + 1) % 100;
			end
		end
		r[0] = (t[0] & 8'h80) | i2bcd(s);
		r[1] = i2bcd(m);
		r[2] = f12 ? (8'h40 | {2'b00, pm, 5'h00} | i2bcd(h)) : i2bcd(h);
		r[3] = (t[3] & 8'h18) | 8'(wk);
		r[4] = i2bcd(d);
		r[5] = {2'b00, (y % 4 == 0), 5'h00} | i2bcd(mo);
		r[6] = i2bcd(y);
		return r;
	endfunction : next_time

	function automatic regs_t rand_time();
		regs_t t;
		int f, mo, y, h;
		f = $urandom % 2;
		mo = $urandom % 12 + 1;
		y = $urandom % 100;
		h = f ? ($urandom % 12 + 1) : $urandom % 24;
		t[0] = i2bcd(($urandom % 2) ? 59 : 50 + $urandom % 10);
		t[1] = i2bcd(($urandom % 2) ? 59 : $urandom % 60);
		t[2] = f ? (8'h40 | {2'b00, 1'($urandom), 5'h00} | i2bcd(h)) : i2bcd(h);
		t[3] = 8'($urandom % 7 + 1);
		t[4] = i2bcd(mdays(mo, y) - $urandom % 2);
		t[5] = i2bcd(mo);
		t[6] = i2bcd(y);
		return t;
	endfunction : rand_time

	// Source is stopped and the flag allowed to drop before new time is loaded
	task automatic run_case(input regs_t t);
		regs_t e;
		e = next_time(t);
		host_u.wr({3'b000, ADDR_CTRL}, 8'h00);
		repeat (FAIL + 5) @(negedge ref_clk);
		for (int i = 0; i < 7; i++) host_u.wr(8'(i), t[i]);
		host_u.wr({3'b000, ADDR_CTRL}, 8'h08);
		edges(DIV);
		host_u.wr({3'b000, ADDR_CTRL}, 8'h00);
		rd(8'h00, 7);
		q[3][RUN_BIT] = 1'b0;
		for (int i = 0; i < 7; i++) begin
			check(q[i], e[i]);
		end
	endtask : run_case

	initial begin
		regs_t cases [7];
		logic [7:0] d;
		bit ok;
		cases = '{'{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99},
			'{8'h59, 8'h59, 8'h71, 8'h03, 8'h28, 8'h02, 8'h23},
			'{8'h59, 8'h59, 8'h23, 8'h01, 8'h28, 8'h02, 8'h24},
			'{8'h59, 8'h59, 8'h51, 8'h02, 8'h30, 8'h04, 8'h25},
			'{8'h59, 8'h59, 8'h72, 8'h04, 8'h30, 8'h06, 8'h21},
			'{8'h59, 8'h59, 8'h09, 8'h05, 8'h31, 8'h01, 8'h00},
			'{8'h59, 8'h59, 8'h23, 8'h06, 8'h30, 8'h04, 8'h01}};
		void'($urandom(32'h17afebd4));
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		host_u.wr(8'h08, 8'hff);
		rd(8'h00, 33);
		foreach (q[i]) check(q[i], (i % 32 < 8) ? RST_MAP[i % 32] : 8'h00);
		host_u.rd_first(8'h20, d, ok);
		check({7'h00, ok}, 8'h00);
		host_u.rd_stop();
		$display("Test reset map done");
		host_u.wr(8'h00, 8'h80);
		repeat (3) @(negedge ref_clk);
		check({7'h00, xtal_out_pin}, 8'h01);
		edges(OSC_RUN_EDGES - 1);
		rd(8'h03, 1);
		check(q[0] & 8'h20, 8'h00);
		edges(1);
		rd(8'h00, 4);
		check(q[3] & 8'h20, 8'h20);
		check(q[0], 8'h88);
		host_u.wr(8'h00, 8'h08);
		repeat (FAIL + 5) @(negedge ref_clk);
		check({7'h00, xtal_out_pin}, 8'h00);
		rd(8'h03, 1);
		check(q[0] & 8'h20, 8'h00);
		edges(DIV);
		rd(8'h00, 1);
		check(q[0], 8'h08);
		$display("Test oscillator status done");
		host_u.wr(8'h01, 8'h10);
		host_u.wr(8'h00, 8'h59);
		host_u.rd_first(8'h00, d, ok);
		check(d, 8'h59);
		host_u.wr({3'b000, ADDR_CTRL}, 8'h08);
		edges(DIV);
		host_u.wr({3'b000, ADDR_CTRL}, 8'h00);
		host_u.rd_more(d, ok);
		check(d, 8'h10);
		repeat (31) host_u.rd_more(d, ok);
		check(d, 8'h00);
		host_u.rd_stop();
		rd(8'h01, 1);
		check(q[0], 8'h11);
		$display("Test read snapshot done");
		foreach (cases[i]) begin
			run_case(cases[i]);
			$display("Test corner case %0d done", i);
		end
		for (int i = 0; i < 20; i++) begin
			run_case(rand_time());
			$display("Test random case %0d done", i);
		end
		finish_test();
	end

	// The tests need about 33 us; six times that marks a hang
	initial begin
		#200_000;
		n_errors++;
		finish_test();
	end
endmodule : rtc_timekeeper_tb
